// ==== rtl/cstx_top.sv ====
// cstx_top.sv: three-wire master transmit channel with APB registers
//
// The implementer's own choices: register access over APB and the register offsets.

// Summary of operation
// (R1) clock out, data out, separate data in
// (R2) frame length 7 or 8 bits
// (R3) order bit picks msb or lsb first
// (R4) serial clock at most fclk over four
// (R5) slave clock limit fmck over six
// (R6) divider field one or more
// (R7) select bit picks prescaler tap a or b
// (R8) interrupt on frame end or buffer empty
// (R9) data phase bit leads data half period
// (R10) clock phase picks change and sample edges
// (R11) clock idles high, low when inverted
// (R12) start trigger enables the channel
// (R13) data pin driven only when output enabled
// (R14) software waits for idle before stopping
// (R15) stop trigger clears channel enabled status
// (R16) software clears output enable after stop
// (R17) stopped channel pins follow level bits; data pin follows its level bit only while output enable is clear
// (R18) peripheral clock removal resets the unit
// (R19) software reinitialises after clock removal
// (R20) writing transmit byte starts a transfer
// (R21) stop trigger reads back as zero
// (R22) one bit per period, interrupt after last
// (R23) no error flag in master transmit
module cstx_top import cstx_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  output logic serial_clock_pin,
  output logic serial_data_out_pin,
  input wire logic serial_data_in_pin,
  // event
  output logic channel_interrupt
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] buf_q;          // transmit_byte_reg
    logic buf_full;             // byte waiting for the shifter
    logic [6:0] div;            // data_reg_upper_divider
    logic [MODE_W-1:0] mode;    // mode_reg_low and comm_setting_high
    logic [7:0] presc;          // prescaler_setting
    logic enabled;              // channel_enabled_status
    logic soe;                  // channel_output_enable
    logic lvl_data;             // data_output_level
    logic lvl_clk;              // clock_output_level
    logic periph_en;            // peripheral_clock_enable
    cstx_state_t st;            // shift engine
    logic [7:0] shreg;          // frame being sent
    logic [3:0] edge_cnt;       // serial clock edges in frame
    logic sck;                  // engine clock level
    logic dout;                 // engine data level
    logic pin_sck;              // registered clock pin
    logic pin_so;               // registered data pin
    logic irq;                  // channel_interrupt pulse
    logic [1:0] din_sync;       // input synchroniser
    logic [31:0] prdata;        // read data for access phase
  } cstx_top_st_t;

  localparam cstx_top_st_t RST_ST = '{
    mode: MODE_RST, div: DIV_RST, presc: PRESC_RST, st: CSTX_IDLE,
    lvl_data: OUT_IDLE, lvl_clk: OUT_IDLE, sck: OUT_IDLE,
    dout: OUT_IDLE, pin_sck: OUT_IDLE, pin_so: OUT_IDLE,
    default: '0};

  cstx_top_st_t r;
  cstx_top_st_t n;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // true for every offset that answers without error
  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return a == OFS_DATA || a == OFS_MODE || a == OFS_PRESC ||
           a == OFS_START || a == OFS_STOP || a == OFS_STATUS ||
           a == OFS_OUTEN || a == OFS_OUTLVL || a == OFS_PERIPH;
  endfunction

  // bit of the frame sent at position idx
  function automatic logic pick(logic [7:0] d, logic [MODE_W-1:0] m,
                                logic [3:0] idx);
    logic [3:0] len;
    len = m[M_LEN8] ? LEN_LONG : LEN_SHORT; // [R2]
    return m[M_LSB] ? d[idx[2:0]] : d[3'(len - 4'h1 - idx)]; // [R3]
  endfunction

  // frame length in bits for the current mode
  function automatic logic [3:0] pick_len(logic [MODE_W-1:0] m);
    return m[M_LEN8] ? LEN_LONG : LEN_SHORT;
  endfunction

  logic wr;
  logic wr_start;
  logic wr_stop;
  logic mck_tick;
  logic tick_a;
  logic tick_b;
  logic half_tick;
  logic [3:0] last_edge;
  logic first_bit;

  assign wr = psel & penable & pwrite;
  assign wr_start = wr && paddr == OFS_START && pwdata[0];
  assign wr_stop = wr && paddr == OFS_STOP && pwdata[0];
  // two edges per bit, last one ends the frame
  assign last_edge = 4'({pick_len(r.mode), 1'b0} - 5'h01); // [R22]
  assign first_bit = pick(r.shreg, r.mode, 4'h0);

  // ------------------------------------------------------------
  // clock generation
  // ------------------------------------------------------------
  // both taps run from fclk; a slave-side clock would need six
  // operation ticks per period, which is why none is accepted here
  cstx_presc u_presc (
    .clk(clk),
    .reset_n(reset_n),
    .run(r.periph_en),
    .exp_a(r.presc[3:0]),
    .exp_b(r.presc[7:4]),
    .tick_a(tick_a),
    .tick_b(tick_b)
  ); // [R5]

  assign mck_tick = r.mode[M_CKSEL] ? tick_b : tick_a; // [R7]

  cstx_div u_div (
    .clk(clk),
    .reset_n(reset_n),
    .mck_tick(mck_tick),
    .div(r.div),
    .run(r.st == CSTX_SHIFT),
    .half_tick(half_tick)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    n.irq = 1'b0;
    n.din_sync = {r.din_sync[0], serial_data_in_pin};
    // shift engine
    case (r.st)
      CSTX_IDLE: begin
        n.sck = ~r.mode[M_CKP]; // [R11]
        if (r.enabled && r.buf_full) begin
          // buffer moves to the shifter, buffer is empty again
          n.shreg = r.buf_q;
          n.buf_full = 1'b0;
          n.edge_cnt = 4'h0;
          n.st = CSTX_SHIFT;
          if (r.mode[M_DAP]) begin
            n.dout = pick(r.buf_q, r.mode, 4'h0); // [R9]
          end
          n.irq = r.mode[M_INTSRC]; // [R8]
        end
      end
      CSTX_SHIFT: begin
        if (half_tick) begin
          n.sck = ~r.sck; // [R10]
          n.edge_cnt = r.edge_cnt + 4'h1;
          // even edges are the change edges
          if (!r.edge_cnt[0] && (!r.mode[M_DAP] || r.edge_cnt != 4'h0)
              ) begin
            n.dout = pick(r.shreg, r.mode, {1'b0, r.edge_cnt[3:1]}); // [R22]
          end
          if (r.edge_cnt == last_edge) begin
            // even toggle count leaves sck at its idle level
            n.st = CSTX_IDLE;
            n.irq = ~r.mode[M_INTSRC]; // [R8] [R22]
          end
        end
      end
      default: begin
        n.st = CSTX_IDLE;
      end
    endcase
    // the stop trigger aborts any frame in progress
    if (wr_stop) begin
      n.enabled = 1'b0; // [R15]
      n.st = CSTX_IDLE;
      n.sck = ~r.mode[M_CKP];
    end
    if (wr_start) begin
      n.enabled = 1'b1; // [R12]
    end
    // register writes
    if (wr) begin
      case (paddr)
        OFS_DATA: begin
          if (pstrb[0]) begin
            // a pending byte is overwritten, not queued
            n.buf_q = pwdata[7:0]; // [R20]
            n.buf_full = 1'b1;
          end
          if (pstrb[1]) begin
            n.div = pwdata[DIV_HI:DIV_LO]; // [R6]
          end
        end
        OFS_MODE: n.mode = pwdata[MODE_W-1:0];
        OFS_PRESC: n.presc = pwdata[7:0];
        OFS_OUTEN: n.soe = pwdata[0];
        OFS_OUTLVL: begin
          n.lvl_data = pwdata[LVL_DATA];
          n.lvl_clk = pwdata[LVL_CLK];
        end
        default: begin
        end
      endcase
    end
    // gated unit: everything back to defaults, writes lost except to peripheral_clock_enable
    if (!r.periph_en) begin
      n = RST_ST; // [R18]
    end
    if (wr && paddr == OFS_PERIPH) begin
      n.periph_en = pwdata[0];
    end
    // clock pin follows the engine only while the channel runs, data pin only while output is enabled
    n.pin_sck = n.enabled ? n.sck : n.lvl_clk; // [R1] [R17]
    n.pin_so = n.soe ? n.dout : n.lvl_data; // [R13] [R17]
    // read data captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_DATA: n.prdata = {16'h0000, r.div, 1'b0, r.buf_q};
        OFS_MODE: n.prdata = {26'h0, r.mode};
        OFS_PRESC: n.prdata = {24'h0, r.presc};
        OFS_STATUS: begin
          // no error bits exist in this mode
          n.prdata = 32'h0; // [R23]
          n.prdata[S_ENABLED] = r.enabled;
          n.prdata[S_BUSY] = (r.st == CSTX_SHIFT) | r.buf_full;
          n.prdata[S_BUFFULL] = r.buf_full;
          n.prdata[S_DIN] = r.din_sync[1];
        end
        OFS_OUTEN: n.prdata = {31'h0, r.soe};
        OFS_OUTLVL: begin
          n.prdata = 32'h0;
          n.prdata[LVL_DATA] = r.lvl_data;
          n.prdata[LVL_CLK] = r.lvl_clk;
        end
        OFS_PERIPH: n.prdata = {31'h0, r.periph_en};
        default: n.prdata = 32'h0; // [R21]
      endcase
    end
  end

  // register the copy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= RST_ST;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign serial_clock_pin = r.pin_sck;
  assign serial_data_out_pin = r.pin_so;
  assign channel_interrupt = r.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_START_SETS: assert property ( // [R12]
    (wr_start && r.periph_en) |=> r.enabled
  ) else $error("start trigger did not enable channel");

  AST_STOP_CLEARS: assert property ( // [R15]
    wr_stop |=> !r.enabled && r.st == CSTX_IDLE
  ) else $error("stop trigger did not halt channel");

  AST_STOP_READS_ZERO: assert property ( // [R21]
    (psel && !penable && !pwrite && paddr == OFS_STOP) |=> prdata == 0
  ) else $error("stop trigger read back nonzero");

  AST_IDLE_CLK: assert property ( // [R11]
    (r.st == CSTX_IDLE && $stable(r.mode))[*2] |-> r.sck == !r.mode[M_CKP]
  ) else $error("idle clock level wrong for clock phase");

  AST_HALF_MIN: assert property ( // [R4]
    half_tick |=> !half_tick
  ) else $error("serial clock faster than fclk/4");

  AST_SCK_TOGGLE: assert property ( // [R10]
    (r.st == CSTX_SHIFT && half_tick && r.periph_en && !wr_stop)
      |=> r.sck != $past(r.sck)
  ) else $error("serial clock missed a half-period toggle");

  AST_FIRST_BIT: assert property ( // [R3]
    (r.st == CSTX_SHIFT && half_tick && r.edge_cnt == 4'h0 &&
     !r.mode[M_DAP] && r.periph_en && !wr_stop)
      |=> r.dout == $past(first_bit)
  ) else $error("first bit not in selected order");

  AST_FRAME_IRQ: assert property ( // [R8]
    (r.st == CSTX_SHIFT && half_tick && r.edge_cnt == last_edge &&
     !r.mode[M_INTSRC] && r.periph_en) |=> channel_interrupt ##1
      !channel_interrupt
  ) else $error("transfer end interrupt missing");

  AST_BUF_IRQ: assert property ( // [R8]
    (r.st == CSTX_IDLE && r.enabled && r.buf_full && r.mode[M_INTSRC] &&
     r.periph_en && !wr_stop) |=> channel_interrupt && r.st == CSTX_SHIFT
  ) else $error("buffer empty interrupt missing");

  AST_SO_GATE: assert property ( // [R13]
    !r.soe |-> serial_data_out_pin == r.lvl_data
  ) else $error("data pin driven while output disabled");

  AST_CLK_MANUAL: assert property ( // [R17]
    !r.enabled |-> serial_clock_pin == r.lvl_clk
  ) else $error("stopped clock pin ignores level bit");

  AST_PERIPH_RESET: assert property ( // [R18]
    !r.periph_en |=> !r.enabled && r.st == CSTX_IDLE && !r.buf_full
  ) else $error("gated unit kept state");
endmodule // cstx_top

// ==== rtl/cstx_pkg.sv ====
// cstx_pkg.sv: register map, field layout and constants of the serial channel
package cstx_pkg;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DATA = 8'h00;     // transmit byte and divider
  localparam logic [7:0] OFS_MODE = 8'h04;     // mode and framing bits
  localparam logic [7:0] OFS_PRESC = 8'h08;    // prescaler_setting
  localparam logic [7:0] OFS_START = 8'h0C;    // channel_start_trigger
  localparam logic [7:0] OFS_STOP = 8'h10;     // channel_stop_trigger
  localparam logic [7:0] OFS_STATUS = 8'h14;   // read-only status
  localparam logic [7:0] OFS_OUTEN = 8'h18;    // serial_output_enable
  localparam logic [7:0] OFS_OUTLVL = 8'h1C;   // manual pin levels
  localparam logic [7:0] OFS_PERIPH = 8'h20;   // peripheral_clock_enable

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DIV_LO = 9;                   // divider in upper byte 7:1
  localparam int DIV_HI = 15;
  localparam int M_INTSRC = 0;                 // interrupt_source_sel
  localparam int M_CKSEL = 1;                  // operation clock select
  localparam int M_DAP = 2;                    // data_phase_sel
  localparam int M_CKP = 3;                    // clock_phase_sel
  localparam int M_LSB = 4;                    // 1: lsb first
  localparam int M_LEN8 = 5;                   // 1: 8-bit frame
  localparam int MODE_W = 6;
  localparam int LVL_DATA = 0;                 // data_output_level
  localparam int LVL_CLK = 8;                  // clock_output_level
  localparam int S_ENABLED = 0;                // channel_enabled_status
  localparam int S_BUSY = 1;                   // transfer_in_progress
  localparam int S_BUFFULL = 2;
  localparam int S_DIN = 3;                    // synchronised data input

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [5:0] MODE_RST = 6'h20;     // 8-bit, msb first
  localparam logic [6:0] DIV_RST = 7'h01;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic OUT_IDLE = 1'b1;            // pins park high
  localparam logic [3:0] LEN_SHORT = 4'h7;
  localparam logic [3:0] LEN_LONG = 4'h8;
  localparam int PRESC_W = 15;                 // taps 2^0 .. 2^15
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned SCK_MIN_RATIO = 4;   // sck never above fclk/4
  localparam logic [6:0] DIV_MIN = 7'h01;

  // ------------------------------------------------------------
  // shift engine states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CSTX_IDLE = 2'b00,
    CSTX_SHIFT = 2'b01
  } cstx_state_t;
endpackage

// ==== rtl/cstx_presc.sv ====
// cstx_presc.sv: free-running prescaler giving two operation clock ticks
module cstx_presc import cstx_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [3:0] exp_a,
  input wire logic [3:0] exp_b,
  // operation clock ticks
  output logic tick_a,
  output logic tick_b
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [PRESC_W-1:0] cnt;  // divide chain
  } cstx_presc_st_t;

  cstx_presc_st_t r;
  cstx_presc_st_t n;

  // tick when the low e bits of the chain are all ones
  function automatic logic tap(logic [PRESC_W-1:0] c, logic [3:0] e);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((32'h1 << e) - 32'h1);
    return (c & m) == m;
  endfunction

  // next state: stopped chain restarts from zero
  always_comb begin
    n = r;
    n.cnt = run ? r.cnt + PRESC_W'(1) : '0;
  end

  // register the copy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ticks are single-cycle enables for the divider
  assign tick_a = run & tap(r.cnt, exp_a);
  assign tick_b = run & tap(r.cnt, exp_b);
endmodule // cstx_presc

// ==== rtl/cstx_div.sv ====
// cstx_div.sv: per-channel divider giving serial half-period ticks
module cstx_div import cstx_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // operation clock and setting
  input wire logic mck_tick,
  input wire logic [6:0] div,
  input wire logic run,
  // one pulse per half serial clock period
  output logic half_tick
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [6:0] cnt;  // operation clock ticks seen
  } cstx_div_st_t;

  cstx_div_st_t r;
  cstx_div_st_t n;
  logic [6:0] div_eff;
  logic wrap;

  // zero is not a legal setting, treat it as the minimum
  assign div_eff = (div < DIV_MIN) ? DIV_MIN : div; // [R6]
  // >= keeps a divider shrunk mid-frame from running away
  assign wrap = r.cnt >= div_eff;

  // next state: half period is div_eff + 1 ticks
  always_comb begin
    n = r;
    if (!run) begin
      n.cnt = '0;
    end else if (mck_tick) begin
      n.cnt = wrap ? 7'h00 : r.cnt + 7'h01;
    end
  end

  // register the copy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign half_tick = run & mck_tick & wrap; // [R4]
endmodule // cstx_div

// ==== testbench/cstx_slave_model.sv ====
// cstx_slave_model.sv: behavioural serial slave that captures sent bits
module cstx_slave_model (
  // serial pins seen from the slave
  input wire logic sck,
  input wire logic sdo,
  // slave setup and capture clear
  input wire logic ckp,
  input wire logic clr,
  // captured bits and bit count
  output logic [15:0] rx,
  output logic [4:0] nbits
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------
  // capture
  // ----------------------------------------------------------
  // samples on the edge that returns to the idle level, so a
  // master that changes data on the wrong edge shows up as bad bits
  always @(sck or posedge clr) begin
    if (clr) begin
      rx <= 16'h0000;
      nbits <= 5'h00;
    end else if (sck !== ckp) begin
      rx <= {rx[14:0], sdo};
      nbits <= nbits + 5'h01;
    end
  end
endmodule // cstx_slave_model

// ==== testbench/cstx_top_tb.sv ====
// cstx_top_tb.sv: self-checking bench of the serial transmit channel
module cstx_top_tb import cstx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic clk, reset_n, psel, penable, pwrite, sdi, pready, pslverr;
  logic [7:0] paddr, lf, b;
  logic [31:0] pwdata, prdata, rd;
  logic sck, sdo, irq, clr, ckp, er, sck_q, l8, lsb, ea, eb, cks;
  logic [15:0] rx;
  logic [4:0] nbits;
  logic [1:0] div;
  int err_total, n_compared, cyc, nirq, n0, iv, last_iv, e, de;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  cstx_top dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock_pin(sck),
    .serial_data_out_pin(sdo), .serial_data_in_pin(sdi),
    .channel_interrupt(irq));

  cstx_slave_model slave (.sck(sck), .sdo(sdo), .ckp(ckp),
    .clr(clr), .rx(rx), .nbits(nbits));

  // ----------------------------------------------------------
  // monitors: cycle count, pulses, clock half period
  // ----------------------------------------------------------
  // values read here are those from before the edge's updates
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) nirq++;
    if (sck !== sck_q) begin
      last_iv = iv;
      iv = 1;
    end else iv++;
    sck_q = sck;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic final_report;
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      err_total++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, er}, 32'h0);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask

  // polls busy under a bound, then lets the last pulse land
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (rd[S_BUSY] !== 1'b0 && k < 300);
    repeat (4) @(posedge clk);
    // a channel that never goes idle is a failure, not a pass
    if (k >= 300) begin
      err_total++;
      final_report();
    end
  endtask

  task automatic pulse_clr;
    clr = 1'b1;
    #1 clr = 1'b0;
  endtask

  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // bits as the slave holds them after one frame
  function automatic logic [7:0] exp_rx(input logic [7:0] v,
                                        input logic w8, input logic lf1);
    int n;
    logic [7:0] r;
    n = w8 ? 8 : 7;
    r = 8'h00;
    for (int i = 0; i < n; i++) r[i] = lf1 ? v[n-1-i] : v[i];
    return r;
  endfunction

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, sdi, clr, ckp} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    lf = 8'h18;
    sck_q = 1'b1;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    // unit gated: writes ignored, defaults hold
    wr(OFS_MODE, 32'h3F);
    rc(OFS_MODE, 32'h20);
    rc(OFS_OUTLVL, 32'h101);
    wr(OFS_PERIPH, 32'h1);
    rc(OFS_OUTEN, 32'h0);
    rc(OFS_STOP, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // byte written before start must wait
    wr(OFS_OUTEN, 32'h1);
    pulse_clr();
    wr(OFS_DATA, 32'h2A5);
    repeat (40) @(posedge clk);
    chk({27'h0, nbits}, 32'h0);
    wr(OFS_START, 32'h1);
    wait_idle();
    chk({16'h0, rx}, 32'hA5);
    wr(OFS_STOP, 32'h1);
    // every framing, order and phase with random data and rate
    for (int m = 0; m < 16; m++) begin
      lf = nx(lf);
      b = lf;
      lf = nx(lf);
      {cks, ea, eb, div} = {lf[5], lf[4], lf[3], lf[1:0]};
      dap_l8(m);
    end
    final_report();
  end

  // one frame with framing picked by m
  task automatic dap_l8(input int m);
    logic dap;
    logic fb;
    {dap, ckp, lsb, l8} = m[3:0];
    fb = lsb ? b[0] : (l8 ? b[7] : b[6]);
    e = cks ? int'(eb) : int'(ea);
    de = (div == 2'h0) ? 1 : int'(div);
    wr(OFS_PRESC, {24'h0, 3'h0, eb, 3'h0, ea});
    wr(OFS_MODE, {26'h0, l8, lsb, ckp, dap, cks, lf[7]});
    wr(OFS_START, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[S_ENABLED]}, 32'h1);
    chk({31'h0, sck}, {31'h0, ~ckp});
    pulse_clr();
    n0 = nirq;
    wr(OFS_DATA, {16'h0, 5'h0, div, 1'b0, b});
    if (dap) begin
      // first bit already on the pin while the clock still idles
      repeat (2) @(posedge clk);
      chk({30'h0, sck, sdo}, {30'h0, ~ckp, fb});
    end
    wait_idle();
    chk({16'h0, rx}, {24'h0, exp_rx(b, l8, lsb)});
    chk({27'h0, nbits}, l8 ? 32'h8 : 32'h7);
    chk(32'(nirq - n0), 32'h1);
    chk(32'(last_iv), 32'((de + 1) << e));
    wr(OFS_STOP, 32'h1);
    if (m == 15) tail();
  endtask

  // back-to-back bytes, urgent stop, manual levels, gating
  task automatic tail;
    ckp = 1'b0;
    wr(OFS_PRESC, 32'h0);
    wr(OFS_MODE, 32'h21);
    wr(OFS_START, 32'h1);
    pulse_clr();
    n0 = nirq;
    wr(OFS_DATA, 32'h2C3);
    wr(OFS_DATA, 32'h25A);
    wait_idle();
    chk({16'h0, rx}, 32'hC35A);
    chk({27'h0, nbits}, 32'h10);
    chk(32'(nirq - n0), 32'h2);
    wr(OFS_DATA, 32'h2FF);
    repeat (6) @(posedge clk);
    wr(OFS_STOP, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[S_ENABLED]}, 32'h0);
    rc(OFS_STOP, 32'h0);
    wr(OFS_OUTEN, 32'h0);
    wr(OFS_OUTLVL, 32'h0);
    repeat (3) @(posedge clk);
    chk({30'h0, sck, sdo}, 32'h0);
    wr(OFS_OUTLVL, 32'h100);
    repeat (3) @(posedge clk);
    chk({30'h0, sck, sdo}, 32'h2);
    sdi <= lf[2];
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[S_DIN]}, {31'h0, sdi});
    wr(OFS_PERIPH, 32'h0);
    wr(OFS_PERIPH, 32'h1);
    rc(OFS_MODE, 32'h20);
    rc(OFS_OUTLVL, 32'h101);
  endtask
endmodule // cstx_top_tb
